// >>> common/pcd_pkg.sv
package pcd_pkg;

  // ****************************************************************
  // Pin slots
  // ****************************************************************
  localparam int NPIN    = 10;
  localparam int PIN_C4  = 0;
  localparam int PIN_C5  = 1;
  localparam int PIN_C6  = 2;
  localparam int PIN_C7  = 3;
  localparam int PIN_C8  = 4;
  localparam int PIN_C12 = 5;
  localparam int PIN_D0  = 6;
  localparam int PIN_D1  = 7;
  localparam int PIN_D4  = 8;
  localparam int PIN_D5  = 9;

  // ****************************************************************
  // Functions and which pins may take them
  // ****************************************************************
  typedef enum logic [2:0] {
    PCD_FN_GPIO,
    PCD_FN_ANALOG,
    PCD_FN_CRYSTAL_OSC_OUTPUT,
    PCD_FN_EXTERNAL_CLOCK_INPUT,
    PCD_FN_JTAG
  } pcd_fn_t;

  localparam logic [NPIN-1:0] OK_GPIO   = 10'h3FF;
  localparam logic [NPIN-1:0] OK_ANALOG = 10'h03F;
  localparam logic [NPIN-1:0] OK_CRYSTAL_OSC_OUTPUT   = 10'h300;
  localparam logic [NPIN-1:0] OK_EXTERNAL_CLOCK_INPUT  = 10'h200;
  localparam logic [NPIN-1:0] OK_JTAG   = 10'h0C0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [NPIN-1:0] RST_JTAG_PINS = 10'h0C0;
  localparam logic [NPIN-1:0] RST_DIR       = 10'h000;
  localparam logic [NPIN-1:0] RST_DOUT      = 10'h000;
  localparam logic            RST_TDO       = 1'h1;
  localparam logic            RST_TDI       = 1'h1;
  localparam logic            RST_TCK_PREV  = 1'h1;
  localparam int              SYNC_STAGES   = 2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] pu;
  } pcd_pad_t;

  typedef struct packed {
    logic [NPIN-1:0] analog_en;
    logic            conv_b_input0_en;
    logic            comparator_b_input3_en;
    logic            crystal_osc_input_en;
    logic            crystal_osc_output_en;
    logic            external_clock_input_en;
  } pcd_route_t;

endpackage

// >>> verilog/pcd_sync.sv
`timescale 1ns/1ps
module pcd_sync #(
  parameter int          WIDTH   = 1,
  parameter int          STAGES  = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [STAGES-1:0][WIDTH-1:0] stg;
  } pcd_sync_st_t;

  pcd_sync_st_t st_r;
  pcd_sync_st_t st_nxt;

  if (STAGES < 2) begin : g_chk
    $error("pcd_sync needs at least two stages");
  end

  // Each stage feeds only the next one; nothing else looks at the first.
  always_comb begin
    st_nxt = st_r;
    st_nxt.stg[0] = d;
    for (int i = 1; i < STAGES; i++) begin
      st_nxt.stg[i] = st_r.stg[i-1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= {STAGES{RST_VAL}};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.stg[STAGES-1];

endmodule

// >>> verilog/pcd_pin_select.sv
//Behaviour
//- Each port C and port D pin is a software-set GPIO input or output.
//- After reset, analog-shared and oscillator-shared pins are GPIO inputs.
//- Converter B input 0 pin as analog feeds converter and comparator both.
//- After reset, port D bits 0 and 1 take the test-data function.
//- Test data input is captured on each rising test clock edge.
//- Test data output is driven only in shift states, otherwise floats.
//- Test data output changes on the falling test clock edge.
//- Test data input keeps its pull-up on, also during reset.
//- Port D bit 5 may become the external clock input.
//- Test data output is tri-stateable and carries the serial test stream.
//- Peripheral selection comes from the system integration unit settings.
`timescale 1ns/1ps
module pcd_pin_select (
  input  wire logic                                core_clk,
  input  wire logic                                rst_n,
  input  wire logic                                ce,
  input  wire logic [pcd_pkg::NPIN-1:0]            pad_in,
  input  wire logic                                tck_pad,
  input  wire logic                                siu_wr,
  input  pcd_pkg::pcd_fn_t [pcd_pkg::NPIN-1:0]     siu_sel,
  input  wire logic                                gpio_wr,
  input  wire logic [pcd_pkg::NPIN-1:0]            gpio_dir_wdata,
  input  wire logic [pcd_pkg::NPIN-1:0]            gpio_out_wdata,
  input  wire logic                                tap_shift,
  input  wire logic                                tap_tdo,
  output pcd_pkg::pcd_pad_t                        pad,
  output pcd_pkg::pcd_route_t                      route,
  output logic      [pcd_pkg::NPIN-1:0]            gpio_in,
  output logic                                     tdi_bit,
  output logic                                     tdi_strobe,
  output logic                                     tck_rise,
  output logic                                     tck_fall
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pcd_pkg::pcd_fn_t [pcd_pkg::NPIN-1:0] sel;
    logic [pcd_pkg::NPIN-1:0]             dir;
    logic [pcd_pkg::NPIN-1:0]             dout;
    logic                                 tck_prev;
    logic                                 tdi;
    logic                                 tdi_stb;
    logic                                 tdo;
    logic                                 tdo_oe;
  } pcd_st_t;

  function automatic pcd_st_t rst_state();
    pcd_st_t s;
    s = '0;
    for (int i = 0; i < pcd_pkg::NPIN; i++) begin
      s.sel[i] = pcd_pkg::RST_JTAG_PINS[i] ? pcd_pkg::PCD_FN_JTAG : pcd_pkg::PCD_FN_GPIO;
    end
    s.dir      = pcd_pkg::RST_DIR;
    s.dout     = pcd_pkg::RST_DOUT;
    s.tck_prev = pcd_pkg::RST_TCK_PREV;
    s.tdi      = pcd_pkg::RST_TDI;
    s.tdo      = pcd_pkg::RST_TDO;
    return s;
  endfunction

  function automatic logic fn_legal(pcd_pkg::pcd_fn_t fn, int idx);
    logic ok;
    ok = 1'b0;
    unique case (fn)
      pcd_pkg::PCD_FN_GPIO:   ok = pcd_pkg::OK_GPIO[idx];
      pcd_pkg::PCD_FN_ANALOG: ok = pcd_pkg::OK_ANALOG[idx];
      pcd_pkg::PCD_FN_CRYSTAL_OSC_OUTPUT:   ok = pcd_pkg::OK_CRYSTAL_OSC_OUTPUT[idx];
      pcd_pkg::PCD_FN_EXTERNAL_CLOCK_INPUT:  ok = pcd_pkg::OK_EXTERNAL_CLOCK_INPUT[idx];
      pcd_pkg::PCD_FN_JTAG:   ok = pcd_pkg::OK_JTAG[idx];
      default:                ok = 1'b0;
    endcase
    return ok;
  endfunction

  localparam pcd_st_t ST_RST = rst_state();

  pcd_st_t                   st_r;
  pcd_st_t                   st_nxt;
  logic [pcd_pkg::NPIN-1:0]  pad_s;
  logic                      tck_s;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  pcd_sync #(
    .WIDTH   (pcd_pkg::NPIN + 1),
    .STAGES  (pcd_pkg::SYNC_STAGES),
    .RST_VAL ('1)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .d        ({tck_pad, pad_in}),
    .q        ({tck_s, pad_s})
  );

  assign tck_rise = tck_s & ~st_r.tck_prev;
  assign tck_fall = ~tck_s & st_r.tck_prev;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt          = st_r;
    st_nxt.tck_prev = tck_s;
    st_nxt.tdi_stb  = 1'b0;
    if (tck_rise) begin
      st_nxt.tdi     = pad_s[pcd_pkg::PIN_D0];
      st_nxt.tdi_stb = 1'b1;
    end
    if (tck_fall) begin
      st_nxt.tdo    = tap_tdo;
      st_nxt.tdo_oe = tap_shift;
    end
    // selection from unit
    // Requests for a function a pin cannot take are dropped per pin.
    if (siu_wr) begin
      for (int i = 0; i < pcd_pkg::NPIN; i++) begin
        if (fn_legal(siu_sel[i], i)) begin
          st_nxt.sel[i] = siu_sel[i];
        end
      end
    end
    if (gpio_wr) begin
      st_nxt.dir  = gpio_dir_wdata;
      st_nxt.dout = gpio_out_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Pad and routing outputs
  // ****************************************************************
  always_comb begin
    pad = '0;
    for (int i = 0; i < pcd_pkg::NPIN; i++) begin
      unique case (st_r.sel[i])
        pcd_pkg::PCD_FN_GPIO: begin
          pad.out[i] = st_r.dout[i];
          pad.oe[i]  = st_r.dir[i] & rst_n;
        end
        pcd_pkg::PCD_FN_JTAG: begin
          pad.out[i] = (i == pcd_pkg::PIN_D1) ? st_r.tdo : 1'b0;
          pad.oe[i]  = (i == pcd_pkg::PIN_D1) ? (st_r.tdo_oe & rst_n) : 1'b0;
          pad.pu[i]  = 1'b1;
        end
        default: begin
          pad.out[i] = 1'b0;
          pad.oe[i]  = 1'b0;
        end
      endcase
    end
    // pull-up through reset
    // The pull-ups hold before the first clock edge settles the selection.
    if (!rst_n) begin
      pad.pu = pad.pu | pcd_pkg::RST_JTAG_PINS;
    end
  end

  always_comb begin
    route = '0;
    for (int i = 0; i < pcd_pkg::NPIN; i++) begin
      route.analog_en[i] = (st_r.sel[i] == pcd_pkg::PCD_FN_ANALOG);
    end
    route.conv_b_input0_en       = route.analog_en[pcd_pkg::PIN_C4];
    route.comparator_b_input3_en = route.analog_en[pcd_pkg::PIN_C4];
    route.crystal_osc_input_en   = (st_r.sel[pcd_pkg::PIN_D4] == pcd_pkg::PCD_FN_CRYSTAL_OSC_OUTPUT);
    route.crystal_osc_output_en  = (st_r.sel[pcd_pkg::PIN_D5] == pcd_pkg::PCD_FN_CRYSTAL_OSC_OUTPUT);
    route.external_clock_input_en = (st_r.sel[pcd_pkg::PIN_D5] == pcd_pkg::PCD_FN_EXTERNAL_CLOCK_INPUT);
  end

  assign gpio_in    = pad_s;
  assign tdi_bit    = st_r.tdi;
  assign tdi_strobe = st_r.tdi_stb;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_reset_gpio_in: assert property ($past(!rst_n) |->
    st_r.sel[pcd_pkg::PIN_C4] == pcd_pkg::PCD_FN_GPIO && st_r.sel[pcd_pkg::PIN_D5] == pcd_pkg::PCD_FN_GPIO
    && pad.oe == '0)
    else $error("pins not GPIO inputs after reset");

  a_reset_test_sel: assert property ($past(!rst_n) |->
    st_r.sel[pcd_pkg::PIN_D0] == pcd_pkg::PCD_FN_JTAG && st_r.sel[pcd_pkg::PIN_D1] == pcd_pkg::PCD_FN_JTAG)
    else $error("test pins not selected after reset");

  a_gpio_drive: assert property ((st_r.sel[pcd_pkg::PIN_C5] == pcd_pkg::PCD_FN_GPIO) |->
    pad.oe[pcd_pkg::PIN_C5] == st_r.dir[pcd_pkg::PIN_C5] && pad.out[pcd_pkg::PIN_C5] == st_r.dout[pcd_pkg::PIN_C5])
    else $error("GPIO pad does not follow direction");

  a_analog_both: assert property ((st_r.sel[pcd_pkg::PIN_C4] == pcd_pkg::PCD_FN_ANALOG) |->
    route.conv_b_input0_en && route.comparator_b_input3_en && !pad.oe[pcd_pkg::PIN_C4])
    else $error("analog pin not routed to both inputs");

  a_tdi_capture: assert property ((tck_rise && ce) |=>
    tdi_strobe && tdi_bit == $past(pad_s[pcd_pkg::PIN_D0]))
    else $error("test input not captured on rise");

  // Only the test function owes a float here; a GPIO output on this pin may legally drive through link activity.
  a_tdo_float: assert property ((tck_fall && ce && !tap_shift
    && st_r.sel[pcd_pkg::PIN_D1] == pcd_pkg::PCD_FN_JTAG) |=>
    !pad.oe[pcd_pkg::PIN_D1])
    else $error("test output driven outside shift");

  // Reset reloads the output bit, so a change straight out of a short reset is exempt.
  a_tdo_fall_edge: assert property (($changed(st_r.tdo) && $past(rst_n)) |-> $past(tck_fall && ce))
    else $error("test output changed off falling edge");

  a_tdi_pullup: assert property ((st_r.sel[pcd_pkg::PIN_D0] == pcd_pkg::PCD_FN_JTAG) |->
    pad.pu[pcd_pkg::PIN_D0])
    else $error("test input pull-up missing");

  a_external_clock_input_pick: assert property ((st_r.sel[pcd_pkg::PIN_D5] == pcd_pkg::PCD_FN_EXTERNAL_CLOCK_INPUT) |->
    route.external_clock_input_en && !route.crystal_osc_output_en && !pad.oe[pcd_pkg::PIN_D5])
    else $error("external clock select wrong");

  a_tdo_stream: assert property ((st_r.sel[pcd_pkg::PIN_D1] == pcd_pkg::PCD_FN_JTAG) |->
    pad.out[pcd_pkg::PIN_D1] == st_r.tdo && pad.oe[pcd_pkg::PIN_D1] == st_r.tdo_oe)
    else $error("test output not on pad");

  a_siu_apply: assert property ((siu_wr && ce && siu_sel[pcd_pkg::PIN_D5] == pcd_pkg::PCD_FN_EXTERNAL_CLOCK_INPUT) |=>
    st_r.sel[pcd_pkg::PIN_D5] == pcd_pkg::PCD_FN_EXTERNAL_CLOCK_INPUT)
    else $error("selection write not applied");

  a_periph_mask: assert property ((st_r.sel[pcd_pkg::PIN_C6] != pcd_pkg::PCD_FN_GPIO) |->
    !pad.oe[pcd_pkg::PIN_C6])
    else $error("peripheral pin driven by GPIO");

  c_tdo_driven: cover property (pad.oe[pcd_pkg::PIN_D1] ##1 tck_fall);
  c_external_clock_input_used: cover property (route.external_clock_input_en);
  c_analog_c4:  cover property (route.conv_b_input0_en);
  c_gpio_out:   cover property (pad.oe[pcd_pkg::PIN_D0]);

endmodule

// >>> verif/pcd_probe.sv
`timescale 1ns/1ps
// ****************************************************************
// Test probe on the far side of the test link
// ****************************************************************
module pcd_probe (
  output logic      tck_pad,
  output logic      tdi_pad,
  input  wire logic tdo_pad
);
  // Both lines idle high: the clock stands still between frames and a released data line floats to its pull-up.
  initial begin
    tck_pad = 1'h1;
    tdi_pad = 1'h1;
  end

  // Output bits are taken late in the high phase, so the core's synchroniser delay cannot make a bit miss its sample.
  task automatic shift(input logic [7:0] din, output logic [7:0] dout);
    for (int i = 0; i < 8; i++) begin
      tck_pad = 1'h0;
      tdi_pad = din[i];
      #40;
      tck_pad = 1'h1;
      #39;
      dout[i] = tdo_pad;
      #1;
    end
    tdi_pad = 1'h1;
  endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  typedef pcd_pkg::pcd_fn_t [pcd_pkg::NPIN-1:0] pcd_sel_t;

  logic                 core_clk  = 1'h0;
  logic                 rst_n     = 1'h0;
  logic                 ce        = 1'h1;
  logic [9:0]           pad_rnd   = 10'h000;
  logic [9:0]           pad_in;
  logic                 siu_wr    = 1'h0;
  pcd_sel_t             siu_sel;
  logic                 gpio_wr   = 1'h0;
  logic [9:0]           dir_w     = 10'h000;
  logic [9:0]           out_w     = 10'h000;
  logic                 tap_shift = 1'h0;
  logic [7:0]           tdo_seq   = 8'h00;
  logic [2:0]           tdo_idx   = 3'h0;
  logic [7:0]           cap       = 8'h00;
  pcd_pkg::pcd_pad_t    pad;
  pcd_pkg::pcd_route_t  route;
  logic [9:0]           gpio_in;
  logic                 tdi_bit;
  logic                 tdi_strobe;
  logic                 tck_rise;
  logic                 tck_fall;
  logic                 tck_pad;
  logic                 tdi_pad;
  wire logic            tdo_pad = pad.oe[7] ? pad.out[7] : 1'h1;
  int                   num_errors  = 0;
  int                   check_count = 0;
  int                   rise_cnt    = 0;

  assign pad_in = {pad_rnd[9:7], tdi_pad, pad_rnd[5:0]};

  always #5 core_clk = ~core_clk;

  pcd_pin_select pcd_pin_select_i (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .ce             (ce),
    .pad_in         (pad_in),
    .tck_pad        (tck_pad),
    .siu_wr         (siu_wr),
    .siu_sel        (siu_sel),
    .gpio_wr        (gpio_wr),
    .gpio_dir_wdata (dir_w),
    .gpio_out_wdata (out_w),
    .tap_shift      (tap_shift),
    .tap_tdo        (tdo_seq[tdo_idx]),
    .pad            (pad),
    .route          (route),
    .gpio_in        (gpio_in),
    .tdi_bit        (tdi_bit),
    .tdi_strobe     (tdi_strobe),
    .tck_rise       (tck_rise),
    .tck_fall       (tck_fall)
  );

  pcd_probe pcd_probe_i (
    .tck_pad (tck_pad),
    .tdi_pad (tdi_pad),
    .tdo_pad (tdo_pad)
  );

  // ****************************************************************
  // Stand-in for the TAP and capture of received bits
  // ****************************************************************
  // Frames are eight bits, so the 3-bit index realigns by itself at each frame.
  always @(posedge core_clk) begin
    if (tck_fall === 1'h1) begin
      tdo_idx <= tdo_idx + 3'h1;
    end
    if (tdi_strobe === 1'h1) begin
      cap <= {tdi_bit, cap[7:1]};
    end
    if (tck_rise === 1'h1) begin
      rise_cnt <= rise_cnt + 1;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic pcd_sel_t def_sel();
    pcd_sel_t s;
    for (int i = 0; i < pcd_pkg::NPIN; i++) begin
      s[i] = (i == pcd_pkg::PIN_D0 || i == pcd_pkg::PIN_D1) ? pcd_pkg::PCD_FN_JTAG : pcd_pkg::PCD_FN_GPIO;
    end
    return s;
  endfunction

  function automatic logic [9:0] gpio_mask(input pcd_sel_t s);
    logic [9:0] m;
    for (int i = 0; i < pcd_pkg::NPIN; i++) begin
      m[i] = (s[i] == pcd_pkg::PCD_FN_GPIO);
    end
    return m;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sel_write(input pcd_sel_t s);
    @(posedge core_clk);
    siu_sel <= s;
    siu_wr  <= 1'h1;
    @(posedge core_clk);
    siu_wr  <= 1'h0;
    #1;
  endtask

  task automatic gpio_write(input logic [9:0] d, input logic [9:0] o);
    @(posedge core_clk);
    dir_w   <= d;
    out_w   <= o;
    gpio_wr <= 1'h1;
    @(posedge core_clk);
    gpio_wr <= 1'h0;
    #1;
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #20000;
    num_errors++;
    stop_test();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    pcd_sel_t   s;
    logic [9:0] d;
    logic [7:0] din;
    logic [7:0] dout;
    logic [7:0] seq;
    siu_sel = def_sel();
    void'($urandom(78247));
    repeat (3) @(posedge core_clk);
    #1;
    chk(pad.pu[7:6], 2'h3);
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    #1;
    chk(pad.oe, 10'h000);
    chk(route, 15'h0000);
    chk(pad.pu[7:6], 2'h3);
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 10'h3FF : 10'($urandom);
      @(posedge core_clk);
      pad_rnd <= 10'($urandom);
      gpio_write(d, 10'($urandom));
      chk(pad.oe, d & gpio_mask(def_sel()));
      chk(pad.out & pad.oe, out_w & d & gpio_mask(def_sel()));
      repeat (3) @(posedge core_clk);
      #1;
      chk(gpio_in, pad_in);
    end
    $display("test gpio done");

    gpio_write(10'h3FF, 10'h2AA);
    s = def_sel();
    s[pcd_pkg::PIN_C4] = pcd_pkg::PCD_FN_ANALOG;
    s[pcd_pkg::PIN_C5] = pcd_pkg::PCD_FN_JTAG;
    s[pcd_pkg::PIN_D0] = pcd_pkg::PCD_FN_GPIO;
    s[pcd_pkg::PIN_D1] = pcd_pkg::PCD_FN_GPIO;
    s[pcd_pkg::PIN_D4] = pcd_pkg::PCD_FN_CRYSTAL_OSC_OUTPUT;
    s[pcd_pkg::PIN_D5] = pcd_pkg::PCD_FN_EXTERNAL_CLOCK_INPUT;
    sel_write(s);
    chk({route.conv_b_input0_en, route.comparator_b_input3_en}, 2'h3);
    chk(route.analog_en, 10'h001);
    chk({route.crystal_osc_input_en, route.external_clock_input_en}, 2'h3);
    chk(pad.oe, 10'h0FE);
    @(posedge core_clk);
    ce <= 1'h0;
    sel_write(def_sel());
    chk(route.external_clock_input_en, 1'h1);
    @(posedge core_clk);
    ce <= 1'h1;
    s[pcd_pkg::PIN_D4] = pcd_pkg::PCD_FN_GPIO;
    s[pcd_pkg::PIN_D5] = pcd_pkg::PCD_FN_CRYSTAL_OSC_OUTPUT;
    sel_write(s);
    chk({route.crystal_osc_output_en, route.external_clock_input_en}, 2'h2);
    sel_write(def_sel());
    chk(route, 15'h0000);
    chk(pad.oe, 10'h33F);
    $display("test select done");

    for (int f = 0; f < 4; f++) begin
      din = (f == 0) ? 8'h00 : 8'($urandom);
      seq = 8'($urandom) & 8'hFE;
      @(posedge core_clk);
      tap_shift <= (f != 1);
      tdo_seq   <= seq;
      #($urandom_range(9, 1));
      pcd_probe_i.shift(din, dout);
      repeat (4) @(posedge core_clk);
      #1;
      chk(cap, din);
      chk(rise_cnt, 8 * (f + 1));
      chk(dout, (f != 1) ? seq : 8'hFF);
      chk(pad.oe[7], (f != 1));
    end
    $display("test link done");
    stop_test();
  end
endmodule
